// *** include/ssr_pkg.sv ***
package ssr_pkg;

    // core clock
    localparam int CLK_PERIOD_NS = 10;

    // spike suppression on both bus lines, longest rejected pulse
    localparam int GLITCH_NS = 100;
    localparam int GLITCH_CYC = (GLITCH_NS / CLK_PERIOD_NS < 1) ? 1 : GLITCH_NS / CLK_PERIOD_NS;
    localparam int GLITCH_CNT_W = 5;

    // fixed upper slave-address nibble per variant
    localparam logic [3:0] GROUP_STD = 4'ha;
    localparam logic [3:0] GROUP_ALT = 4'hb;

    // array geometry
    localparam int WORD_W = 8;
    localparam int PTR_W = 8;
    localparam int MEM_WORDS_LARGE = 256;
    localparam int MEM_WORDS_SMALL = 128;
    localparam logic [7:0] PTR_MASK_LARGE = 8'hff;
    localparam logic [7:0] PTR_MASK_SMALL = 8'h7f;

    // reset values and bits per byte
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] BITCNT_RST = 4'h0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // write buffer between bus engine and array
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_WIDTH = PTR_W + WORD_W;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WORD,
        ST_WDATA,
        ST_ACK,
        ST_TX,
        ST_MACK
    } ssr_state_t;

endpackage

// *** core/ssr_fifo.sv ***
`timescale 1ns/100ps
module ssr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic push;
    logic pop;

    // extra pointer bit tells full from empty
    assign in_ready = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
    assign out_valid = (wr_ptr_reg != rd_ptr_reg);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = store[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
        end else if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_ptr_reg <= '0;
        end else if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end
endmodule

// *** core/ssr_slave.sv ***
`timescale 1ns/100ps
module ssr_slave #(
    parameter bit ALT_GROUP = 1'b0,
    parameter bit SMALL_ARRAY = 1'b0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // serial bus, open drain data
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // straps and power save
    input wire logic strap_addr_bit0,
    input wire logic strap_addr_bit1,
    input wire logic strap_addr_bit2,
    input wire logic power_save,
    // status
    output logic bus_busy,
    output logic power_save_active
);
    localparam logic [3:0] GROUP = ALT_GROUP ? ssr_pkg::GROUP_ALT : ssr_pkg::GROUP_STD;
    localparam logic [7:0] PTR_MASK = SMALL_ARRAY ? ssr_pkg::PTR_MASK_SMALL : ssr_pkg::PTR_MASK_LARGE;
    localparam logic [ssr_pkg::GLITCH_CNT_W-1:0] GLITCH_LIM = ssr_pkg::GLITCH_CNT_W'(ssr_pkg::GLITCH_CYC);

    logic [ssr_pkg::WORD_W-1:0] mem [0:ssr_pkg::MEM_WORDS_LARGE-1];

    // pin sampling and filtering, index 0 is clock, 1 is data
    logic [1:0] pin_raw;
    logic [1:0] sync0_reg;
    logic [1:0] sync1_reg;
    logic [1:0] filt_reg;
    logic [1:0] filt_prev_reg;
    logic [2:0] strap_sync0_reg;
    logic [2:0] strap_sync1_reg;
    logic [1:0] ps_sync_reg;
    logic bus_rst;

    // bus engine
    ssr_pkg::ssr_state_t state_reg;
    ssr_pkg::ssr_state_t after_ack_reg;
    logic [3:0] bitcnt_reg;
    logic [7:0] rx_reg;
    logic [7:0] tx_reg;
    logic [7:0] ptr_reg;
    logic fetch_pend_reg;
    logic sda_oe_reg;

    // decoded events
    logic scl_f;
    logic sda_f;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic in_rx;
    logic byte_end;
    logic addr_hit;
    logic ack_now;
    logic fetch_load;
    logic [2:0] tx_idx;

    // write buffer
    logic wbuf_in_valid;
    logic wbuf_in_ready;
    logic wbuf_out_valid;
    logic wbuf_out_ready;
    logic [ssr_pkg::FIFO_WIDTH-1:0] wbuf_in_data;
    logic [ssr_pkg::FIFO_WIDTH-1:0] wbuf_out_data;

    function automatic logic [7:0] ptr_step(input logic [7:0] p);
        ptr_step = (p + 8'h01) & PTR_MASK;
    endfunction

    assign pin_raw = {sda_in, scl_in};

    // two flops before anything looks at a pin
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync0_reg <= 2'h3;
            sync1_reg <= 2'h3;
        end else begin
            sync0_reg <= pin_raw;
            sync1_reg <= sync0_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            strap_sync0_reg <= 3'h0;
            strap_sync1_reg <= 3'h0;
            ps_sync_reg <= 2'h0;
        end else begin
            strap_sync0_reg <= {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
            strap_sync1_reg <= strap_sync0_reg;
            ps_sync_reg <= {ps_sync_reg[0], power_save};
        end
    end

    assign bus_rst = rst || ps_sync_reg[1];

    // a line level is taken only after it held longer than the spike limit
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_filt
            logic [ssr_pkg::GLITCH_CNT_W-1:0] cnt_reg;
            always_ff @(posedge core_clk) begin
                if (bus_rst) begin
                    cnt_reg <= '0;
                    filt_reg[gi] <= 1'b1;
                end else if (sync1_reg[gi] == filt_reg[gi]) begin
                    cnt_reg <= '0;
                end else if (cnt_reg == GLITCH_LIM) begin
                    cnt_reg <= '0;
                    filt_reg[gi] <= sync1_reg[gi];
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (bus_rst) begin
            filt_prev_reg <= 2'h3;
        end else begin
            filt_prev_reg <= filt_reg;
        end
    end

    assign scl_f = filt_reg[0];
    assign sda_f = filt_reg[1];
    assign scl_rise = scl_f && !filt_prev_reg[0];
    assign scl_fall = !scl_f && filt_prev_reg[0];
    // data moving under a high clock is a condition, never a bit
    assign start_det = scl_f && filt_prev_reg[0] && !sda_f && filt_prev_reg[1];
    assign stop_det = scl_f && filt_prev_reg[0] && sda_f && !filt_prev_reg[1];

    assign in_rx = (state_reg == ssr_pkg::ST_ADDR) || (state_reg == ssr_pkg::ST_WORD) ||
        (state_reg == ssr_pkg::ST_WDATA);
    assign byte_end = scl_fall && (bitcnt_reg == ssr_pkg::BITS_PER_BYTE);
    assign addr_hit = (rx_reg[7:4] == GROUP) && (rx_reg[3:1] == strap_sync1_reg);

    // a full buffer refuses the byte with a missing ack
    always_comb begin
        case (state_reg)
            ssr_pkg::ST_ADDR: ack_now = addr_hit;
            ssr_pkg::ST_WORD: ack_now = 1'b1;
            ssr_pkg::ST_WDATA: ack_now = wbuf_in_ready;
            default: ack_now = 1'b0;
        endcase
    end

    // reads wait for pending writes so the data is never stale
    assign fetch_load = fetch_pend_reg && !wbuf_out_valid;
    assign tx_idx = 3'(4'h7 - bitcnt_reg);

    // protocol state
    always_ff @(posedge core_clk) begin
        if (bus_rst) begin
            state_reg <= ssr_pkg::ST_IDLE;
            after_ack_reg <= ssr_pkg::ST_IDLE;
            bitcnt_reg <= ssr_pkg::BITCNT_RST;
        end else if (start_det) begin
            state_reg <= ssr_pkg::ST_ADDR;
            bitcnt_reg <= ssr_pkg::BITCNT_RST;
        end else if (stop_det) begin
            state_reg <= ssr_pkg::ST_IDLE;
            bitcnt_reg <= ssr_pkg::BITCNT_RST;
        end else begin
            case (state_reg)
                ssr_pkg::ST_ADDR, ssr_pkg::ST_WORD, ssr_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        bitcnt_reg <= bitcnt_reg + 4'h1;
                    end else if (byte_end) begin
                        if (ack_now) begin
                            state_reg <= ssr_pkg::ST_ACK;
                            if (state_reg == ssr_pkg::ST_ADDR) begin
                                after_ack_reg <= rx_reg[0] ? ssr_pkg::ST_TX : ssr_pkg::ST_WORD;
                            end else begin
                                after_ack_reg <= ssr_pkg::ST_WDATA;
                            end
                        end else begin
                            state_reg <= ssr_pkg::ST_IDLE;
                        end
                    end
                end
                ssr_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        state_reg <= after_ack_reg;
                        bitcnt_reg <= ssr_pkg::BITCNT_RST;
                    end
                end
                ssr_pkg::ST_TX: begin
                    if (scl_rise) begin
                        bitcnt_reg <= bitcnt_reg + 4'h1;
                    end else if (byte_end) begin
                        state_reg <= ssr_pkg::ST_MACK;
                    end
                end
                ssr_pkg::ST_MACK: begin
                    if (scl_rise && sda_f) begin
                        state_reg <= ssr_pkg::ST_IDLE;
                    end else if (scl_fall) begin
                        state_reg <= ssr_pkg::ST_TX;
                        bitcnt_reg <= ssr_pkg::BITCNT_RST;
                    end
                end
                default: begin
                    state_reg <= ssr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // incoming bits are taken on the clock rise
    always_ff @(posedge core_clk) begin
        if (bus_rst) begin
            rx_reg <= ssr_pkg::BYTE_RST;
        end else if (in_rx && scl_rise) begin
            rx_reg <= {rx_reg[6:0], sda_f};
        end
    end

    // data line drive, changed only just after a clock fall
    always_ff @(posedge core_clk) begin
        if (bus_rst || start_det || stop_det) begin
            sda_oe_reg <= 1'b0;
        end else if (in_rx && byte_end) begin
            sda_oe_reg <= ack_now;
        end else if (state_reg == ssr_pkg::ST_ACK && scl_fall) begin
            sda_oe_reg <= (after_ack_reg == ssr_pkg::ST_TX) && !tx_reg[7];
        end else if (state_reg == ssr_pkg::ST_TX && scl_fall) begin
            sda_oe_reg <= !byte_end && !tx_reg[tx_idx];
        end else if (state_reg == ssr_pkg::ST_MACK && scl_fall) begin
            sda_oe_reg <= !tx_reg[7];
        end else if (state_reg == ssr_pkg::ST_MACK || state_reg == ssr_pkg::ST_IDLE) begin
            sda_oe_reg <= 1'b0;
        end
    end

    // read fetch is requested at the address ack and at every master ack
    always_ff @(posedge core_clk) begin
        if (bus_rst) begin
            fetch_pend_reg <= 1'b0;
        end else if (state_reg == ssr_pkg::ST_ADDR && byte_end && addr_hit && rx_reg[0]) begin
            fetch_pend_reg <= 1'b1;
        end else if (state_reg == ssr_pkg::ST_MACK && scl_rise && !sda_f) begin
            fetch_pend_reg <= 1'b1;
        end else if (fetch_load) begin
            fetch_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (bus_rst) begin
            tx_reg <= ssr_pkg::BYTE_RST;
        end else if (fetch_load) begin
            tx_reg <= mem[ptr_reg];
        end
    end

    // pointer keeps its value across transfers, only bus reset clears it
    always_ff @(posedge core_clk) begin
        if (bus_rst) begin
            ptr_reg <= ssr_pkg::PTR_RST;
        end else if (state_reg == ssr_pkg::ST_WORD && byte_end) begin
            ptr_reg <= rx_reg & PTR_MASK;
        end else if (wbuf_in_valid && wbuf_in_ready) begin
            ptr_reg <= ptr_step(ptr_reg);
        end else if (fetch_load) begin
            ptr_reg <= ptr_step(ptr_reg);
        end
    end

    // each accepted data byte goes to the buffer with its address
    assign wbuf_in_valid = (state_reg == ssr_pkg::ST_WDATA) && byte_end;
    assign wbuf_in_data = {ptr_reg, rx_reg};
    // the array port is shared; a fetch never overlaps a drain
    assign wbuf_out_ready = !fetch_load;

    ssr_fifo #(
        .WIDTH(ssr_pkg::FIFO_WIDTH),
        .DEPTH(ssr_pkg::FIFO_DEPTH)
    ) u_wbuf (
        .clk(core_clk),
        .rst(bus_rst),
        .in_valid(wbuf_in_valid),
        .in_ready(wbuf_in_ready),
        .in_data(wbuf_in_data),
        .out_valid(wbuf_out_valid),
        .out_ready(wbuf_out_ready),
        .out_data(wbuf_out_data)
    );

    // array content survives bus reset, as a static ram should
    always_ff @(posedge core_clk) begin
        if (wbuf_out_valid && wbuf_out_ready) begin
            mem[wbuf_out_data[15:8]] <= wbuf_out_data[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bus_busy <= 1'b0;
        end else begin
            bus_busy <= (state_reg != ssr_pkg::ST_IDLE) || wbuf_out_valid;
        end
    end

    assign power_save_active = ps_sync_reg[1];
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_reg;
endmodule

// *** verification/ssr_slave_asserts.sv ***
`timescale 1ns/100ps
module ssr_slave_asserts (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // straps and power save
    input wire logic strap_addr_bit0,
    input wire logic strap_addr_bit1,
    input wire logic strap_addr_bit2,
    input wire logic power_save,
    // status
    input wire logic bus_busy,
    input wire logic power_save_active
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // raw clock high run; long runs mean the filtered clock is high too
    logic [7:0] scl_hi_reg;
    always_ff @(posedge core_clk) begin
        if (rst || !scl_in) begin
            scl_hi_reg <= 8'h00;
        end else if (scl_hi_reg != 8'hff) begin
            scl_hi_reg <= scl_hi_reg + 8'h01;
        end
    end

    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !sda_oe && !bus_busy)
        else $error("outputs active after reset");
    a_open_drain: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    a_oe_stable_high: assert property (scl_hi_reg > 8'h14 |-> $stable(sda_oe))
        else $error("data drive changed while clock high");
    a_oe_moves_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data drive changed outside clock low");
    a_start_busy: assert property ($fell(sda_in) && scl_in |-> ##[1:20] bus_busy)
        else $error("start not recognised");
    a_stop_idle: assert property ($rose(sda_in) && scl_in |-> ##[1:200] !bus_busy)
        else $error("stop did not return to idle");
    a_psave_copy: assert property (power_save [*5] |-> power_save_active)
        else $error("power save not reported");
    a_psave_quiet: assert property (power_save [*5] |-> !sda_oe && !bus_busy)
        else $error("bus logic active in power save");
endmodule

bind ssr_slave ssr_slave_asserts u_asserts (.core_clk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe,
    .strap_addr_bit0, .strap_addr_bit1, .strap_addr_bit2, .power_save, .bus_busy, .power_save_active);

// *** verification/ssr_master.sv ***
`timescale 1ns/100ps
module ssr_master (
    // bench clock
    input wire logic clk,
    // bus lines
    output logic scl = 1'b1,
    output logic sda_low = 1'b0,
    input wire logic sda
);
    // quarter bit, well above spike filter plus sync latency
    localparam int QTR = 20;
    logic glitch = 1'b0;

    task automatic qwait(input int n);
        repeat (n) @(negedge clk);
    endtask

    // clock stands high between frames
    task automatic start_cond();
        sda_low = 1'b0;
        qwait(QTR);
        scl = 1'b1;
        qwait(QTR);
        sda_low = 1'b1;
        qwait(QTR);
        scl = 1'b0;
        qwait(QTR);
    endtask

    task automatic stop_cond();
        sda_low = 1'b1;
        qwait(QTR);
        scl = 1'b1;
        qwait(QTR);
        sda_low = 1'b0;
        qwait(2 * QTR);
    endtask

    // data moves only while clock low
    task automatic bit_x(input logic b, output logic r);
        sda_low = !b;
        qwait(QTR);
        scl = 1'b1;
        qwait(QTR);
        if (glitch) begin
            scl = 1'b0;
            qwait(6);
            scl = 1'b1;
        end
        r = sda;
        qwait(QTR);
        scl = 1'b0;
        qwait(QTR);
    endtask

    task automatic byte_x(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(!mack, ack);
    endtask
endmodule

// *** verification/tb_ssr_slave.sv ***
`timescale 1ns/100ps
module tb_ssr_slave;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] strap = 3'h5;
    logic power_save = 1'b0;
    logic scl;
    logic m_low;
    logic sda_w;
    logic sda_oe;
    logic sda_out;
    logic sda_oe_alt;
    logic sda_out_alt;
    logic bus_busy;
    logic ps_act;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [7:0] mem [2][256];
    bit alt_sel = 1'b0;
    logic [7:0] ptr = 8'h00;
    logic [7:0] q;
    logic a;

    always #5 core_clk = !core_clk;
    assign sda_w = !(m_low || (sda_oe && !sda_out) || (sda_oe_alt && !sda_out_alt));

    ssr_slave DUT (.core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]),
        .power_save(power_save), .bus_busy(bus_busy), .power_save_active(ps_act));
    ssr_master M (.clk(core_clk), .scl(scl), .sda_low(m_low), .sda(sda_w));
    // expansion device, small array, straps inverted so only one answers
    ssr_slave #(.ALT_GROUP(1'b1), .SMALL_ARRAY(1'b1)) DUT_ALT (.core_clk(core_clk), .rst(rst), .scl_in(scl),
        .sda_in(sda_w), .sda_out(sda_out_alt), .sda_oe(sda_oe_alt), .strap_addr_bit0(!strap[0]),
        .strap_addr_bit1(!strap[1]), .strap_addr_bit2(!strap[2]), .power_save(power_save), .bus_busy(),
        .power_save_active());

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic addr_phase(input logic [3:0] grp, input logic [2:0] s, input logic rw, output logic ack);
        M.start_cond();
        M.byte_x({grp, s, rw}, 1'b0, q, ack);
    endtask

    // the expansion device holds 128 words, so its pointer wraps early
    function automatic logic [7:0] ptr_mask();
        return alt_sel ? ssr_pkg::PTR_MASK_SMALL : ssr_pkg::PTR_MASK_LARGE;
    endfunction

    task automatic wr(input logic [7:0] wa, input int n, input bit stop);
        logic [7:0] d;
        addr_phase(alt_sel ? ssr_pkg::GROUP_ALT : ssr_pkg::GROUP_STD, alt_sel ? ~strap : strap, 1'b0, a);
        chk("addr ack", 8'(a), 8'h00);
        M.byte_x(wa, 1'b0, q, a);
        chk("word ack", 8'(a), 8'h00);
        ptr = wa & ptr_mask();
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            M.byte_x(d, 1'b0, q, a);
            chk("data ack", 8'(a), 8'h00);
            mem[alt_sel][ptr] = d;
            ptr = (ptr + 8'h01) & ptr_mask();
        end
        if (stop)
            M.stop_cond();
    endtask

    // repeated start right after a word address gives a pointer-then-read
    task automatic rd(input int n);
        addr_phase(alt_sel ? ssr_pkg::GROUP_ALT : ssr_pkg::GROUP_STD, alt_sel ? ~strap : strap, 1'b1, a);
        chk("read addr ack", 8'(a), 8'h00);
        for (int i = 0; i < n; i++) begin
            M.byte_x(8'hff, i < n - 1, q, a);
            chk("read data", q, mem[alt_sel][ptr]);
            ptr = (ptr + 8'h01) & ptr_mask();
        end
        M.stop_cond();
        chk("released", 8'(sda_oe || sda_oe_alt), 8'h00);
        chk("idle after stop", 8'(bus_busy), 8'h00);
    endtask

    initial begin
        void'($urandom(64));
        repeat (16) @(negedge core_clk);
        chk("oe in reset", 8'(sda_oe), 8'h00);
        rst = 1'b0;
        repeat (20) @(negedge core_clk);
        for (int s = 0; s < 8; s++) begin
            strap = 3'(s);
            repeat (4) @(negedge core_clk);
            addr_phase(ssr_pkg::GROUP_STD, strap, 1'b0, a);
            M.stop_cond();
            chk("probe ack", 8'(a), 8'h00);
            addr_phase(s[0] ? ssr_pkg::GROUP_ALT : ssr_pkg::GROUP_STD,
                s[0] ? strap : strap ^ 3'(1 << (s % 3)), 1'b0, a);
            M.stop_cond();
            chk("stranger ack", 8'(a), 8'h01);
        end
        strap = 3'($urandom);
        repeat (4) @(negedge core_clk);
        wr(8'hfc, 8, 1);
        wr(8'hfc, 0, 0);
        rd(6);
        rd(2);
        M.glitch = 1'b1;
        wr(8'h40, 3, 1);
        M.glitch = 1'b0;
        wr(8'h40, 0, 0);
        rd(3);
        power_save = 1'b1;
        repeat (10) @(negedge core_clk);
        chk("power save flag", 8'(ps_act), 8'h01);
        power_save = 1'b0;
        repeat (5000) @(negedge core_clk);
        ptr = 8'h00;
        rd(4);
        wr(8'h80, 12, 1);
        wr(8'h80, 0, 0);
        rd(12);
        // small array: word address is masked and the pointer wraps at 128
        alt_sel = 1'b1;
        wr(8'hfc, 6, 1);
        wr(8'hfc, 0, 0);
        rd(6);
        tally_and_finish();
    end

    // whole run is near 82k cycles
    initial begin
        #950_000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule
